// ---- verilog/asl_pkg.sv ----
`default_nettype none
package asl_pkg;
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_LIMIT = 8'h04;
	localparam logic [7:0] OFF_BIAS  = 8'h08;
	localparam logic [7:0] OFF_CMD   = 8'h0C;
	localparam logic [7:0] OFF_NEW   = 8'h10;
	localparam logic [7:0] OFF_ACC   = 8'h14;
	localparam logic [7:0] OFF_DEC   = 8'h18;
	localparam logic [7:0] OFF_STAT  = 8'h1C;
	localparam logic [7:0] OFF_ERR   = 8'h20;
	localparam logic [7:0] OFF_WARN  = 8'h24;
	localparam logic [7:0] OFF_SPD   = 8'h28;
	localparam int B_START  = 0;
	localparam int B_SPCHG  = 1;
	localparam int B_TPCHG  = 2;
	localparam int B_STOP   = 3;
	localparam int B_LIMSEL = 4;
	localparam int B_DIR    = 5;
	localparam int B_METH   = 6;
	localparam int B_MODE   = 8;
	localparam int B_BUSY   = 16;
	localparam int B_CALC   = 17;
	localparam logic [15:0] CTRL_PULSES = 16'h0009;
	localparam logic [15:0] CTRL_RST    = 16'h0000;
	localparam logic [31:0] LIMIT_RST   = 32'h0000FFFF;
	localparam logic [31:0] SPD_RST     = 32'h00000000;
	localparam logic [15:0] TIME_RST    = 16'h0000;
	localparam logic [15:0] TIME_MAX    = 16'h7FFF;
	localparam logic [15:0] W_RANGE = 16'h03FC;
	localparam logic [15:0] W_NOCHG = 16'h03FE;
	localparam logic [15:0] E_HWLP  = 16'h044C;
	localparam logic [15:0] E_HWLM  = 16'h044D;
	localparam logic [15:0] E_RETRY = 16'h04B2;
	localparam logic [15:0] E_ACC   = 16'h05DE;
	localparam logic [15:0] E_DEC   = 16'h05DF;
	localparam logic [15:0] CODE_NONE = 16'h0000;
	localparam logic [15:0] ST_IDLE = 16'h0000;
	localparam logic [15:0] ST_RUN  = 16'h0001;
	localparam logic [15:0] ST_ERR  = 16'hFFFF;
	localparam int CLK_NS   = 10;
	localparam int CALC_NS  = 1000;
	localparam int CALC_CYC = (CALC_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [2:0] {
		M_POS = 3'h0, M_SPD = 3'h1, M_SWSPD = 3'h2, M_SWPOS = 3'h3, M_JOG = 3'h4, M_OPR = 3'h5
	} asl_mode_t;
	typedef enum logic [1:0] {
		P_ACC = 2'h0, P_CONST = 2'h1, P_CHG = 2'h2, P_DEC = 2'h3
	} asl_phase_t;
	typedef enum logic [1:0] {
		R_DOG = 2'h0, R_CNT1 = 2'h1, R_CNT2 = 2'h2
	} asl_meth_t;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01, S_RUN = 5'h02, S_OPR = 5'h04, S_RETRY = 5'h08, S_STOP = 5'h10
	} asl_state_t;
endpackage
`default_nettype wire

// ---- verilog/asl_reg_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface asl_reg_if;
	logic [15:0] ctrl;
	logic        start;
	logic        stop;
	logic        clr_err;
	logic        clr_warn;
	logic [31:0] limit;
	logic [31:0] bias;
	logic [31:0] cmd;
	logic [31:0] nspd;
	logic [15:0] acc;
	logic [15:0] dec;
	logic [31:0] stat;
	logic [15:0] err;
	logic [15:0] warn;
	logic [31:0] spd;
	modport slv (
		output ctrl, start, stop, clr_err, clr_warn, limit, bias, cmd, nspd, acc, dec,
		input  stat, err, warn, spd
	);
	modport core (
		input  ctrl, start, stop, clr_err, clr_warn, limit, bias, cmd, nspd, acc, dec,
		output stat, err, warn, spd
	);
endinterface
`default_nettype wire

// ---- verilog/asl_clamp.sv ----
`timescale 1ns/1ns
`default_nettype none
module asl_clamp #(
	parameter int W = 32
) (
	input  wire logic [W-1:0] spd,
	input  wire logic [W-1:0] lim,
	input  wire logic [W-1:0] bias,
	input  wire logic         use_bias,
	output logic      [W-1:0] out,
	output logic              oor
);
	always_comb begin
		out = spd;
		oor = 1'b0;
		if (spd > lim) begin // [RULE_13]
			out = lim;
			oor = 1'b1;
		end else if (use_bias && spd < bias) begin // [RULE_14]
			out = bias;
			oor = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/asl_apb.sv ----
`timescale 1ns/1ns
`default_nettype none
module asl_apb (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	asl_reg_if.slv           rif
);
	logic        acc_ph;
	logic        wr;
	logic        hit;
	logic [31:0] rd;

	// one wait state: data is muxed while pready is still low
	assign acc_ph = psel & penable & ~pready;
	assign wr     = psel & penable & pready & pwrite;

	always_comb begin
		hit = 1'b1;
		rd  = 32'h00000000;
		case (paddr)
			asl_pkg::OFF_CTRL:  rd = {16'h0000, rif.ctrl};
			asl_pkg::OFF_LIMIT: rd = rif.limit;
			asl_pkg::OFF_BIAS:  rd = rif.bias;
			asl_pkg::OFF_CMD:   rd = rif.cmd;
			asl_pkg::OFF_NEW:   rd = rif.nspd;
			asl_pkg::OFF_ACC:   rd = {16'h0000, rif.acc};
			asl_pkg::OFF_DEC:   rd = {16'h0000, rif.dec};
			asl_pkg::OFF_STAT:  rd = rif.stat;
			asl_pkg::OFF_ERR:   rd = {16'h0000, rif.err};
			asl_pkg::OFF_WARN:  rd = {16'h0000, rif.warn};
			asl_pkg::OFF_SPD:   rd = rif.spd;
			default:            hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= acc_ph;
			if (acc_ph) begin
				prdata  <= pwrite ? 32'h00000000 : rd;
				pslverr <= ~hit;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rif.ctrl  <= asl_pkg::CTRL_RST;
			rif.limit <= asl_pkg::LIMIT_RST;
			rif.bias  <= asl_pkg::SPD_RST;
			rif.cmd   <= asl_pkg::SPD_RST;
			rif.nspd  <= asl_pkg::SPD_RST;
			rif.acc   <= asl_pkg::TIME_RST;
			rif.dec   <= asl_pkg::TIME_RST;
		end else if (wr) begin
			case (paddr)
				asl_pkg::OFF_CTRL:  rif.ctrl <= pwdata[15:0] & ~asl_pkg::CTRL_PULSES;
				asl_pkg::OFF_LIMIT: rif.limit <= pwdata;
				asl_pkg::OFF_BIAS:  rif.bias <= pwdata;
				asl_pkg::OFF_CMD:   rif.cmd <= pwdata;
				asl_pkg::OFF_NEW:   rif.nspd <= pwdata;
				asl_pkg::OFF_ACC:   rif.acc <= pwdata[15:0];
				asl_pkg::OFF_DEC:   rif.dec <= pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rif.start    <= 1'b0;
			rif.stop     <= 1'b0;
			rif.clr_err  <= 1'b0;
			rif.clr_warn <= 1'b0;
		end else begin
			rif.start    <= wr && paddr == asl_pkg::OFF_CTRL && pwdata[asl_pkg::B_START];
			rif.stop     <= wr && paddr == asl_pkg::OFF_CTRL && pwdata[asl_pkg::B_STOP];
			rif.clr_err  <= wr && paddr == asl_pkg::OFF_ERR;
			rif.clr_warn <= wr && paddr == asl_pkg::OFF_WARN;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/asl_axis.sv ----
// Operation
// RULE_01 - return started on dog: dog method goes creep, count methods retry
// RULE_02 - no limit selected means no retry reversal, axis keeps moving
// RULE_03 - dog method start in limit-off and dog-on overlap gives 1202, stop
// RULE_04 - overlap of limit-off and dog-on during retry gives 1202, stop
// RULE_05 - opposite limit going off during return gives 1100/1101, stop
// RULE_06 - return refused with 1100/1101 when opposite limit already off
// RULE_07 - no speed limiting during return; tool keeps return speed legal
// RULE_08 - positioning command speed above limit is clamped, warning 1020
// RULE_09 - jog speed above limit is clamped, warning 1020
// RULE_10 - program supplies new speed, change ramp time and stop time
// RULE_11 - speed change accepted per control and motion phase matrix
// RULE_12 - refused change warns 1022; stop or jog deceleration ignore silently
// RULE_13 - new speed above limit runs at limit, warning 1020
// RULE_14 - new speed below bias runs at bias, warning 1020
// RULE_15 - change requests refused while earlier change calculation runs
// RULE_16 - new speed applied only after current pulse completes
// RULE_17 - target reached during change in position phase gives 1022
// RULE_18 - target change accepted same cycle cancels speed change, 1022
// RULE_19 - position phase ends at target even above bias speed
// RULE_20 - bias 0 and new speed 0 stops axis, busy and status held
// RULE_21 - bias nonzero and new speed 0 runs at bias, warning 1020
// RULE_22 - ramp time errors set status -1, stop using old timing
// RULE_23 - change captured on command rising edge against current phase
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module asl_axis #(
	parameter int CALC_CYC = asl_pkg::CALC_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        near_dog,
	input  wire logic        lim_fwd,
	input  wire logic        lim_rev,
	input  wire logic [1:0]  prof_phase,
	input  wire logic        prof_stopped,
	input  wire logic        target_reached,
	input  wire logic        pulse_done,
	output logic             motion_run,
	output logic             motion_dir,
	output logic      [31:0] speed_cmd,
	output logic             creep_sel,
	output logic             decel_stop,
	output logic             dec_time_sel,
	output logic             axis_busy_flag,
	output logic      [15:0] axis_operation_status
);
	localparam int CW = $clog2(CALC_CYC + 1);
	localparam logic [CW-1:0] CALC_LOAD = CW'(CALC_CYC);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	localparam logic [CW-1:0] CNT_ZERO = CW'(0);

	asl_reg_if rif ();

	asl_apb u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.paddr   (paddr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rif     (rif)
	);

	asl_pkg::asl_state_t state;
	asl_pkg::asl_mode_t  mode;
	asl_pkg::asl_mode_t  run_mode;
	asl_pkg::asl_meth_t  meth;
	asl_pkg::asl_phase_t phase;
	logic          odir;
	logic          limsel;
	logic          opp_ok;
	logic          ret_ok;
	logic [15:0]   opp_code;
	logic          spc_q;
	logic          tpc_q;
	logic          spc_edge;
	logic          tpc_ev;
	logic [CW-1:0] calc_cnt;
	logic          pend;
	logic          calc_busy;
	logic [31:0]   new_q;
	logic          dog_seen;
	logic          chg_ok;
	logic          chg_warn;
	logic          eval;
	logic          take;
	logic          tm_err;
	logic          go;
	logic          pos_mode;
	logic          cancel_tgt;
	logic          apply;
	logic          st_start;
	logic          st_err_set;
	logic [15:0]   st_err_code;
	logic          opr_err;
	logic [15:0]   opr_code;
	logic [31:0]   start_spd;
	logic          start_oor;
	logic [31:0]   chg_spd;
	logic          chg_oor;
	logic          warn_set;
	logic [15:0]   warn_code;
	logic [15:0]   err_q;
	logic [15:0]   warn_q;

	assign mode   = asl_pkg::asl_mode_t'(rif.ctrl[asl_pkg::B_MODE +: 3]);
	assign meth   = asl_pkg::asl_meth_t'(rif.ctrl[asl_pkg::B_METH +: 2]);
	assign phase  = asl_pkg::asl_phase_t'(prof_phase);
	assign odir   = rif.ctrl[asl_pkg::B_DIR];
	assign limsel = rif.ctrl[asl_pkg::B_LIMSEL];
	// limit inputs are high while the switch is on, i.e. inside the stroke
	assign opp_ok   = odir ? lim_rev : lim_fwd;
	assign ret_ok   = odir ? lim_fwd : lim_rev;
	assign opp_code = odir ? asl_pkg::E_HWLM : asl_pkg::E_HWLP;

	asl_clamp u_start_clamp (
		.spd      (rif.cmd),
		.lim      (rif.limit),
		.bias     (rif.bias),
		.use_bias (1'b0),
		.out      (start_spd),
		.oor      (start_oor)
	);

	asl_clamp u_chg_clamp (
		.spd      (rif.nspd),
		.lim      (rif.limit),
		.bias     (rif.bias),
		.use_bias (1'b1),
		.out      (chg_spd),
		.oor      (chg_oor)
	);

	assign st_start = state == asl_pkg::S_IDLE && rif.start;
	assign spc_edge = rif.ctrl[asl_pkg::B_SPCHG] & ~spc_q; // [RULE_23]
	assign tpc_ev   = rif.ctrl[asl_pkg::B_TPCHG] & ~tpc_q & (state == asl_pkg::S_RUN);
	assign calc_busy = calc_cnt != CNT_ZERO || pend;
	assign pos_mode = run_mode == asl_pkg::M_POS || run_mode == asl_pkg::M_SWPOS;

	// acceptance matrix against the phase seen in the edge cycle
	always_comb begin
		chg_ok   = 1'b0;
		chg_warn = 1'b0;
		if (state != asl_pkg::S_STOP) begin // [RULE_12]
			case (run_mode)
				asl_pkg::M_POS, asl_pkg::M_SWPOS: begin // [RULE_11]
					chg_ok   = phase == asl_pkg::P_CONST;
					chg_warn = phase != asl_pkg::P_CONST;
				end
				asl_pkg::M_SPD, asl_pkg::M_SWSPD: begin // [RULE_11]
					chg_ok   = phase != asl_pkg::P_DEC;
					chg_warn = phase == asl_pkg::P_DEC;
				end
				asl_pkg::M_JOG: begin
					chg_ok = phase != asl_pkg::P_DEC; // [RULE_12]
				end
				default: begin
					chg_warn = 1'b1; // [RULE_12]
				end
			endcase
		end
	end

	assign eval   = spc_edge && !calc_busy && axis_busy_flag; // [RULE_15]
	assign take   = eval && chg_ok && !tpc_ev; // [RULE_18]
	assign tm_err = take && (rif.acc > asl_pkg::TIME_MAX || rif.dec > asl_pkg::TIME_MAX);
	assign go     = take && !tm_err;
	assign cancel_tgt = calc_busy && pos_mode && target_reached; // [RULE_17]
	assign apply  = pend && pulse_done && !cancel_tgt && state == asl_pkg::S_RUN; // [RULE_16]

	// return checks; start-time checks refuse, run-time checks stop
	always_comb begin
		st_err_set  = 1'b0;
		st_err_code = asl_pkg::CODE_NONE;
		opr_err     = 1'b0;
		opr_code    = asl_pkg::CODE_NONE;
		if (st_start && mode == asl_pkg::M_OPR) begin
			if (!opp_ok) begin // [RULE_06]
				st_err_set  = 1'b1;
				st_err_code = opp_code;
			end else if (meth == asl_pkg::R_DOG && near_dog && !ret_ok) begin // [RULE_03]
				st_err_set  = 1'b1;
				st_err_code = asl_pkg::E_RETRY;
			end
		end
		if (state == asl_pkg::S_OPR || state == asl_pkg::S_RETRY) begin
			if (!opp_ok) begin // [RULE_05]
				opr_err  = 1'b1;
				opr_code = opp_code;
			end else if (state == asl_pkg::S_RETRY && near_dog && !ret_ok) begin // [RULE_04]
				opr_err  = 1'b1;
				opr_code = asl_pkg::E_RETRY;
			end
		end
	end

	// 1022 outranks 1020 when both land in one cycle
	always_comb begin
		warn_set  = 1'b1;
		warn_code = asl_pkg::W_NOCHG;
		if ((eval && chg_warn) || (eval && chg_ok && tpc_ev) || cancel_tgt) begin
			warn_code = asl_pkg::W_NOCHG; // [RULE_18]
		end else if (go && chg_oor) begin
			warn_code = asl_pkg::W_RANGE; // [RULE_21]
		end else if (st_start && mode != asl_pkg::M_OPR && start_oor) begin
			warn_code = asl_pkg::W_RANGE; // [RULE_08] [RULE_09]
		end else begin
			warn_set = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn_q <= asl_pkg::CODE_NONE;
		end else if (warn_set) begin
			warn_q <= warn_code;
		end else if (rif.clr_warn) begin
			warn_q <= asl_pkg::CODE_NONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= asl_pkg::CODE_NONE;
		end else if (st_err_set) begin
			err_q <= st_err_code;
		end else if (opr_err) begin
			err_q <= opr_code;
		end else if (tm_err) begin
			err_q <= rif.acc > asl_pkg::TIME_MAX ? asl_pkg::E_ACC : asl_pkg::E_DEC;
		end else if (rif.clr_err) begin
			err_q <= asl_pkg::CODE_NONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spc_q    <= 1'b0;
			tpc_q    <= 1'b0;
			calc_cnt <= CNT_ZERO;
			pend     <= 1'b0;
			new_q    <= asl_pkg::SPD_RST;
		end else begin
			spc_q <= rif.ctrl[asl_pkg::B_SPCHG];
			tpc_q <= rif.ctrl[asl_pkg::B_TPCHG];
			if (state != asl_pkg::S_RUN || cancel_tgt || apply) begin
				calc_cnt <= CNT_ZERO;
				pend     <= 1'b0;
			end else if (go) begin
				calc_cnt <= CALC_LOAD;
				new_q    <= chg_spd; // [RULE_13] [RULE_14]
			end else if (calc_cnt != CNT_ZERO) begin
				calc_cnt <= calc_cnt - CNT_ONE;
				pend     <= calc_cnt == CNT_ONE;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state          <= asl_pkg::S_IDLE;
			run_mode       <= asl_pkg::M_POS;
			motion_run     <= 1'b0;
			motion_dir     <= 1'b0;
			speed_cmd      <= asl_pkg::SPD_RST;
			creep_sel      <= 1'b0;
			decel_stop     <= 1'b0;
			dec_time_sel   <= 1'b0;
			axis_busy_flag <= 1'b0;
			axis_operation_status <= asl_pkg::ST_IDLE;
			dog_seen       <= 1'b0;
		end else begin
			case (state)
				asl_pkg::S_IDLE: begin
					if (st_start && st_err_set) begin
						axis_operation_status <= asl_pkg::ST_ERR;
					end else if (st_start) begin
						state          <= mode == asl_pkg::M_OPR ? asl_pkg::S_OPR : asl_pkg::S_RUN;
						run_mode       <= mode;
						motion_run     <= 1'b1;
						motion_dir     <= odir;
						decel_stop     <= 1'b0;
						dec_time_sel   <= 1'b0;
						creep_sel      <= 1'b0;
						dog_seen       <= 1'b0;
						axis_busy_flag <= 1'b1;
						axis_operation_status <= asl_pkg::ST_RUN;
						// return speed passes unlimited
						speed_cmd <= mode == asl_pkg::M_OPR ? rif.cmd : start_spd; // [RULE_07] [RULE_08]
						if (mode == asl_pkg::M_OPR && near_dog) begin
							if (meth == asl_pkg::R_DOG) begin
								creep_sel <= 1'b1; // [RULE_01]
							end else if (limsel) begin
								state      <= asl_pkg::S_RETRY; // [RULE_01] [RULE_02]
								motion_dir <= ~odir;
								dog_seen   <= 1'b1;
							end
						end
					end
				end
				asl_pkg::S_OPR: begin
					if (opr_err) begin
						state      <= asl_pkg::S_STOP;
						decel_stop <= 1'b1;
						axis_operation_status <= asl_pkg::ST_ERR;
					end else if (!ret_ok && limsel) begin
						state      <= asl_pkg::S_RETRY; // [RULE_02]
						motion_dir <= ~odir;
					end else if (prof_stopped) begin
						state          <= asl_pkg::S_IDLE;
						motion_run     <= 1'b0;
						axis_busy_flag <= 1'b0;
						axis_operation_status <= asl_pkg::ST_IDLE;
					end
				end
				asl_pkg::S_RETRY: begin
					if (opr_err) begin
						state      <= asl_pkg::S_STOP;
						decel_stop <= 1'b1;
						axis_operation_status <= asl_pkg::ST_ERR;
					end else if (dog_seen && !near_dog) begin
						state      <= asl_pkg::S_OPR;
						motion_dir <= odir;
					end else if (near_dog) begin
						dog_seen <= 1'b1;
					end
				end
				asl_pkg::S_RUN: begin
					if (apply) begin
						speed_cmd    <= new_q; // [RULE_16] [RULE_20]
						dec_time_sel <= 1'b1;
					end
					if (tm_err) begin
						// old stop timing kept: dec_time_sel untouched
						state      <= asl_pkg::S_STOP; // [RULE_22]
						decel_stop <= 1'b1;
						motion_run <= speed_cmd != asl_pkg::SPD_RST;
						axis_operation_status <= asl_pkg::ST_ERR;
					end else if (pos_mode && target_reached) begin
						// may end above bias when stop time exceeds the rest
						state          <= asl_pkg::S_IDLE; // [RULE_19]
						motion_run     <= 1'b0;
						axis_busy_flag <= 1'b0;
						axis_operation_status <= asl_pkg::ST_IDLE;
					end else if (rif.stop) begin
						state      <= asl_pkg::S_STOP;
						decel_stop <= 1'b1;
					end else if (prof_stopped && speed_cmd != asl_pkg::SPD_RST) begin
						state          <= asl_pkg::S_IDLE;
						motion_run     <= 1'b0;
						axis_busy_flag <= 1'b0;
						axis_operation_status <= asl_pkg::ST_IDLE;
					end
				end
				asl_pkg::S_STOP: begin
					if (prof_stopped) begin
						state          <= asl_pkg::S_IDLE;
						motion_run     <= 1'b0;
						decel_stop     <= 1'b0;
						axis_busy_flag <= 1'b0;
						// an error stop keeps -1 until the next start
						if (axis_operation_status != asl_pkg::ST_ERR) begin
							axis_operation_status <= asl_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state <= asl_pkg::S_IDLE;
				end
			endcase
			if (rif.stop && (state == asl_pkg::S_OPR || state == asl_pkg::S_RETRY)) begin
				state      <= asl_pkg::S_STOP;
				decel_stop <= 1'b1;
			end
		end
	end

	assign rif.stat = {14'h0000, calc_busy, axis_busy_flag, axis_operation_status};
	assign rif.err  = err_q;
	assign rif.warn = warn_q;
	assign rif.spd  = speed_cmd;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ready;
		pend && pulse_done && state == asl_pkg::S_RUN && !cancel_tgt;
	endsequence

	sequence s_applied;
		speed_cmd == $past(new_q) && dec_time_sel;
	endsequence

	a_apply_pulse: assert property (s_ready |=> s_applied) // [RULE_16]
		else $error("new speed not applied at pulse end");
	a_hold_pulse: assert property ( // [RULE_16]
		state == asl_pkg::S_RUN && !pulse_done && !(st_start) |=> speed_cmd == $past(speed_cmd))
		else $error("speed changed without pulse end");
	a_opp_start: assert property ( // [RULE_06]
		st_start && mode == asl_pkg::M_OPR && !opp_ok
		|=> state == asl_pkg::S_IDLE && !motion_run && err_q == $past(opp_code))
		else $error("return started with opposite limit off");
	a_dog_creep: assert property ( // [RULE_01]
		st_start && mode == asl_pkg::M_OPR && opp_ok && ret_ok && near_dog && meth == asl_pkg::R_DOG
		|=> creep_sel && state == asl_pkg::S_OPR)
		else $error("dog method did not start at creep");
	a_retry_nolim: assert property ( // [RULE_02]
		state == asl_pkg::S_OPR && !limsel && !opr_err && !rif.stop
		|=> state != asl_pkg::S_RETRY)
		else $error("retry without selected limit");
	a_retry_overlap: assert property ( // [RULE_04]
		state == asl_pkg::S_RETRY && opp_ok && near_dog && !ret_ok
		|=> err_q == asl_pkg::E_RETRY && decel_stop && state == asl_pkg::S_STOP)
		else $error("overlap in retry not flagged");
	a_opr_noclamp: assert property ( // [RULE_07]
		st_start && mode == asl_pkg::M_OPR && !st_err_set |=> speed_cmd == $past(rif.cmd))
		else $error("return speed was limited");
	a_start_clamp: assert property ( // [RULE_08]
		st_start && mode != asl_pkg::M_OPR && rif.cmd > rif.limit
		|=> speed_cmd == $past(rif.limit) && warn_q == asl_pkg::W_RANGE)
		else $error("command speed not clamped");
	a_calc_refuse: assert property ( // [RULE_15]
		state == asl_pkg::S_RUN && spc_edge && calc_cnt > CNT_ONE && !cancel_tgt
		|=> calc_cnt == $past(calc_cnt) - CNT_ONE && new_q == $past(new_q))
		else $error("change taken during calculation");
	a_tpc_cancel: assert property ( // [RULE_18]
		eval && chg_ok && tpc_ev |=> warn_q == asl_pkg::W_NOCHG && !calc_busy)
		else $error("simultaneous target change not cancelled");
	a_time_err: assert property ( // [RULE_22]
		tm_err |=> axis_operation_status == asl_pkg::ST_ERR && decel_stop
		&& dec_time_sel == $past(dec_time_sel))
		else $error("ramp time error handling wrong");
	a_zero_hold: assert property ( // [RULE_20]
		s_ready ##0 (new_q == asl_pkg::SPD_RST && !tm_err && !target_reached && !rif.stop)
		|=> axis_busy_flag && axis_operation_status == $past(axis_operation_status))
		else $error("zero speed dropped busy or status");
endmodule
`default_nettype wire

// ---- test/asl_drive.sv ----
`timescale 1ns/1ns
`default_nettype none
module asl_drive (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       motion_run,
	input  wire logic       decel_stop,
	input  wire logic [1:0] phase_set,
	output logic      [1:0] prof_phase,
	output logic            prof_stopped,
	output logic            pulse_done
);
	logic [1:0] cnt;
	// a pulse ends every fourth cycle, so a change has to wait for it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			pulse_done <= 1'b0;
			prof_stopped <= 1'b0;
		end else begin
			cnt <= cnt + 2'h1;
			pulse_done <= motion_run && cnt == 2'h3;
			prof_stopped <= decel_stop;
		end
	end
	assign prof_phase = decel_stop ? 2'h3 : phase_set;
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic        lim_rev, run, dstop, pdone, pstop, dog, crp, dts;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [1:0]  phs, pph;
	int          n_mismatch, checked;
	logic [31:0] nsp [3] = '{32'h5, 32'h300, 32'h0};
	logic [31:0] esp [3] = '{32'h10, 32'h100, 32'h10};
	always #5 pclk = ~pclk;
	asl_axis #(.CALC_CYC(4)) asl_axis_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .near_dog(dog), .lim_fwd(1'b1), .lim_rev(lim_rev),
		.prof_phase(pph), .prof_stopped(pstop), .target_reached(1'b0), .pulse_done(pdone),
		.motion_run(run), .motion_dir(), .speed_cmd(), .creep_sel(crp), .decel_stop(dstop),
		.dec_time_sel(dts), .axis_busy_flag(), .axis_operation_status());
	asl_drive asl_drive_inst (.pclk(pclk), .presetn(presetn), .motion_run(run),
		.decel_stop(dstop), .phase_set(phs), .prof_phase(pph), .prof_stopped(pstop),
		.pulse_done(pdone));
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rv = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) begin
			n_mismatch++;
			close_out();
		end
	endtask
	// polls until the value shows up, giving up after 40 reads so a hang counts as a mismatch
	task automatic wt(input logic [7:0] a, input logic [31:0] e, input string n);
		int k;
		k = 0;
		do begin
			apb(1'b0, a, 32'h0);
			k++;
		end while (rv !== e && k < 40);
		chk(n, e, rv);
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lim_rev = 1'b1;
		dog = 1'b0;
		phs = 2'h1;
		n_mismatch = 0;
		checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		wt(asl_pkg::OFF_STAT, 32'h0, "status");
		wt(asl_pkg::OFF_LIMIT, asl_pkg::LIMIT_RST, "limit");
		apb(1'b1, asl_pkg::OFF_LIMIT, 32'h100);
		apb(1'b1, asl_pkg::OFF_BIAS, 32'h10);
		apb(1'b1, asl_pkg::OFF_CMD, 32'h200);
		apb(1'b1, asl_pkg::OFF_ACC, 32'h10);
		apb(1'b1, asl_pkg::OFF_DEC, 32'h10);
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0111);
		wt(asl_pkg::OFF_SPD, 32'h100, "clamped speed");
		wt(asl_pkg::OFF_WARN, {16'h0, asl_pkg::W_RANGE}, "warning");
		wt(asl_pkg::OFF_STAT, 32'h00010001, "running");
		$display("test clamp done");
		for (int j = 0; j < 3; j++) begin
			apb(1'b1, asl_pkg::OFF_WARN, 32'h0);
			apb(1'b1, asl_pkg::OFF_NEW, nsp[j]);
			apb(1'b1, asl_pkg::OFF_CTRL, 32'h0112);
			apb(1'b1, asl_pkg::OFF_CTRL, 32'h0110);
			wt(asl_pkg::OFF_SPD, esp[j], "new speed");
			chk("change timing", 32'h1, {31'h0, dts});
			wt(asl_pkg::OFF_WARN, {16'h0, asl_pkg::W_RANGE}, "warning");
		end
		$display("test speed change done");
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0008);
		wt(asl_pkg::OFF_STAT, 32'h0, "idle");
		phs <= 2'h0;
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0011);
		apb(1'b1, asl_pkg::OFF_WARN, 32'h0);
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0012);
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0010);
		wt(asl_pkg::OFF_WARN, {16'h0, asl_pkg::W_NOCHG}, "refused");
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0008);
		wt(asl_pkg::OFF_STAT, 32'h0, "idle");
		$display("test refusal done");
		apb(1'b0, 8'h40, 32'h0);
		chk("slave error", 32'h1, {31'h0, slv});
		chk("unmapped read", 32'h0, rv);
		$display("test unmapped done");
		lim_rev <= 1'b0;
		apb(1'b1, asl_pkg::OFF_ERR, 32'h0);
		apb(1'b1, asl_pkg::OFF_CMD, 32'h200);
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0531);
		wt(asl_pkg::OFF_ERR, {16'h0, asl_pkg::E_HWLM}, "stroke error");
		chk("no motion", 32'h0, {31'h0, run});
		$display("test return refused done");
		lim_rev <= 1'b1;
		dog <= 1'b1;
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0531);
		wt(asl_pkg::OFF_STAT, 32'h00010001, "return running");
		wt(asl_pkg::OFF_SPD, 32'h200, "return speed");
		chk("creep", 32'h1, {31'h0, crp});
		apb(1'b1, asl_pkg::OFF_CTRL, 32'h0008);
		wt(asl_pkg::OFF_STAT, 32'h0, "idle");
		$display("test dog return done");
		close_out();
	end
endmodule
`default_nettype wire
